// ==== hdl/tap_event_map.vh ====
// Register indices, field positions, reset values and window scales of the tap detector.
// Assumes word-aligned APB access: byte address is four times the index.
`ifndef TAP_EVENT_MAP_VH
`define TAP_EVENT_MAP_VH

`define IDX_PEAK_POLICY      8'h73
`define IDX_LEVEL_REBOUND    8'h74
`define IDX_PRESTILL_WINDOW  8'h75
`define IDX_TIMING_AXIS      8'h76
`define IDX_TAP_STATUS       8'h77

`define ADDR_PEAK_POLICY     10'h1CC
`define ADDR_LEVEL_REBOUND   10'h1D0
`define ADDR_PRESTILL_WINDOW 10'h1D4
`define ADDR_TIMING_AXIS     10'h1D8
`define ADDR_TAP_STATUS      10'h1DC

`define BIT_HOLD_TO_WINDOW   7
`define BIT_TRIPLE_EN        7
`define BIT_DOUBLE_EN        6
`define BIT_SINGLE_EN        5

`define RST_BYTE             8'h00
`define RST_TIMING           16'h0000

`define HISTORY_DEPTH        14
`define LATENCY_DEFAULT      9'h010
`define AXIS_NONE            2'h0
`define AXIS_X               2'h1
`define AXIS_Y               2'h2
`define AXIS_Z               2'h3

`endif

// ==== hdl/tap_event_detector.v ====
// Tap recognition on one selected accelerometer axis, configured over APB.
// Assumes samples arrive from logic on pclk with a one-cycle sample_valid strobe.
//
// How it works
// (RQ1) Without hold option, flag raised immediately for every enabled tap level.
// (RQ2) With hold option, only highest tap level reached gets its flag.
// (RQ3) Hold: flag at once at highest enabled level, else at latency expiry.
// (RQ4) 6-bit peak threshold, 62.5 mg per count; peak must reach it.
// (RQ5) Triple, double, single enables reset to 0; disabled level never flags.
// (RQ6) 5-bit rebound wait, 2 samples per step; zero disables rebound.
// (RQ7) 14-sample history; start field picks first quiet-check sample, oldest is 0.
// (RQ8) 4-bit quiet-check length up to 14 samples; zero disables check.
// (RQ9) Latency field zero means 16 samples, else 32 samples per step.
// (RQ10) Axis selector: 00 none (default), 01 X, 10 Y, 11 Z.
// (RQ11) 6-bit shock wait, 2 samples per step, up to 126 samples.
// (RQ12) Software sets quiet threshold nonzero before relying on detection.
// (RQ13) Every window counts output samples only, never pclk cycles.
//
// Chosen here: the APB register port.
`timescale 1ns/1ps
`include "tap_event_map.vh"

module tap_event_detector #(
  parameter SAMPLE_W  = 16,
  parameter THS_SHIFT = 4
) (
  input  wire                pclk,
  input  wire                presetn,
  input  wire                psel,
  input  wire                penable,
  input  wire                pwrite,
  input  wire [9:0]          paddr,
  input  wire [31:0]         pwdata,
  output reg  [31:0]         prdata,
  output reg                 pready,
  output reg                 pslverr,
  input  wire                sample_valid,
  input  wire [SAMPLE_W-1:0] sample_x,
  input  wire [SAMPLE_W-1:0] sample_y,
  input  wire [SAMPLE_W-1:0] sample_z,
  output reg                 tap_event,
  output reg  [1:0]          tap_level
);

  localparam ST_IDLE    = 2'd0;
  localparam ST_WAIT    = 2'd1;
  localparam ST_REBOUND = 2'd2;
  localparam ST_LATENCY = 2'd3;

  reg [7:0]          peak_policy;
  reg [7:0]          level_rebound;
  reg [7:0]          prestill_window;
  reg [15:0]         timing_axis;
  reg [2:0]          sticky;
  reg [1:0]          state;
  reg [1:0]          taps;
  reg [8:0]          cnt;
  reg [SAMPLE_W-1:0] hist [0:`HISTORY_DEPTH-1];

  wire       hold_mode      = peak_policy[`BIT_HOLD_TO_WINDOW];
  wire [5:0] shock_peak_threshold     = peak_policy[5:0];
  wire [3:0] lvl_en         = {level_rebound[`BIT_TRIPLE_EN], level_rebound[`BIT_DOUBLE_EN],
                               level_rebound[`BIT_SINGLE_EN], 1'b0};
  wire [3:0] quiet_check_first_sample = prestill_window[7:4];
  wire [3:0] quiet_check_sample_count = prestill_window[3:0];
  wire [1:0] axis_sel       = timing_axis[1:0];
  wire [5:0] shock_wait     = timing_axis[7:2];
  wire [3:0] latency_field  = timing_axis[11:8];
  wire [3:0] quiet_before_threshold   = timing_axis[15:12];

  // (RQ11) shock wait length
  wire [8:0] wait_len    = {2'b00, shock_wait, 1'b0};
  // (RQ6) rebound length, zero bypasses
  wire [8:0] rebound_len = {3'b000, level_rebound[4:0], 1'b0};
  // (RQ9) latency window length
  wire [8:0] latency_len = (latency_field == 4'h0) ? `LATENCY_DEFAULT : {latency_field, 5'b00000};
  // (RQ5) highest enabled level ends a sequence
  wire [1:0] max_lvl = lvl_en[3] ? 2'd3 : (lvl_en[2] ? 2'd2 : (lvl_en[1] ? 2'd1 : 2'd0));
  // (RQ7) a start past the last sample is held at the last one
  wire [3:0] quiet_start = (quiet_check_first_sample > 4'd13) ? 4'd13 : quiet_check_first_sample;

  reg [SAMPLE_W-1:0] cur;
  reg [SAMPLE_W:0]   mag;
  reg                quiet_ok;
  reg [SAMPLE_W:0]   dev;
  integer            i;
  integer            j;
  integer            k;

  function [SAMPLE_W:0] absdiff;
    input [SAMPLE_W-1:0] a;
    input [SAMPLE_W-1:0] b;
    reg   [SAMPLE_W:0]   d;
    begin
      d = {a[SAMPLE_W-1], a} - {b[SAMPLE_W-1], b};
      absdiff = d[SAMPLE_W] ? (~d + 1'b1) : d;
    end
  endfunction

  always @*
  begin
    // (RQ10) axis selection
    case (axis_sel)
      `AXIS_X: cur = sample_x;
      `AXIS_Y: cur = sample_y;
      `AXIS_Z: cur = sample_z;
      default: cur = {SAMPLE_W{1'b0}};
    endcase
    mag = absdiff(cur, {SAMPLE_W{1'b0}});
    // (RQ7) quiet check walks the history from the chosen start
    // (RQ8) a zero count leaves the check passing
    quiet_ok = 1'b1;
    dev = {(SAMPLE_W+1){1'b0}};
    for (i = 0; i < `HISTORY_DEPTH; i = i + 1)
    begin
      dev = absdiff(hist[i], hist[quiet_start]);
      if ((i >= quiet_start) && (i < quiet_start + quiet_check_sample_count) &&
          (dev > ({{(SAMPLE_W-3){1'b0}}, quiet_before_threshold} << THS_SHIFT)))
        quiet_ok = 1'b0;
    end
  end

  // (RQ4) peak must reach threshold; (RQ10) no axis, no tap
  wire peak_hit = (axis_sel != `AXIS_NONE) && (max_lvl != 2'd0) &&
                  (mag >= ({{(SAMPLE_W-5){1'b0}}, shock_peak_threshold} << THS_SHIFT));
  wire tap_seen = peak_hit && quiet_ok;
  wire [1:0] taps_up  = taps + 2'd1;
  wire       seq_done = (taps_up == max_lvl);

  // State following a tap once wait and rebound are skipped or spent
  wire [1:0] tail_state = seq_done ? ST_IDLE : ST_LATENCY;
  wire [1:0] post_wait  = (rebound_len != 9'd0) ? ST_REBOUND : tail_state;
  wire [1:0] post_tap   = (wait_len != 9'd0) ? ST_WAIT : post_wait;

  // (RQ1) immediate flag when not holding
  // (RQ3) holding: immediate only at highest enabled level
  wire emit_tap = tap_seen && (state == ST_IDLE || state == ST_LATENCY) &&
                  (hold_mode ? seq_done : lvl_en[taps_up]);

  wire apb_setup = psel && !penable;
  wire apb_write = psel && penable && pready && pwrite && !pslverr;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state     <= ST_IDLE;
      taps      <= 2'd0;
      cnt       <= 9'd0;
      tap_event <= 1'b0;
      tap_level <= 2'd0;
      for (j = 0; j < `HISTORY_DEPTH; j = j + 1)
        hist[j] <= {SAMPLE_W{1'b0}};
    end
    else
    begin
      tap_event <= 1'b0;
      // (RQ13) all windows advance on sample strobes only
      if (sample_valid)
      begin
        for (j = 0; j < `HISTORY_DEPTH - 1; j = j + 1)
          hist[j] <= hist[j+1];
        hist[`HISTORY_DEPTH-1] <= cur;
        if (emit_tap)
        begin
          tap_event <= 1'b1;
          tap_level <= taps_up;
        end
        case (state)
          ST_IDLE, ST_LATENCY:
          begin
            if (tap_seen)
            begin
              taps  <= seq_done ? 2'd0 : taps_up;
              cnt   <= 9'd0;
              state <= post_tap;
            end
            else if (state == ST_LATENCY)
            begin
              if (cnt + 9'd1 >= latency_len)
              begin
                // (RQ2) hold mode flags only the level reached
                // (RQ3) deferred flag at window expiry
                if (hold_mode && lvl_en[taps])
                begin
                  tap_event <= 1'b1;
                  tap_level <= taps;
                end
                taps  <= 2'd0;
                cnt   <= 9'd0;
                state <= ST_IDLE;
              end
              else
                cnt <= cnt + 9'd1;
            end
          end
          ST_WAIT:
          begin
            // (RQ11) shock settles before rebound or latency
            if (cnt + 9'd1 >= wait_len)
            begin
              cnt   <= 9'd0;
              state <= (rebound_len != 9'd0) ? ST_REBOUND : ((taps == 2'd0) ? ST_IDLE : ST_LATENCY);
            end
            else
              cnt <= cnt + 9'd1;
          end
          default:
          begin
            // (RQ6) peaks ignored until rebound ends
            if (cnt + 9'd1 >= rebound_len)
            begin
              cnt   <= 9'd0;
              state <= (taps == 2'd0) ? ST_IDLE : ST_LATENCY;
            end
            else
              cnt <= cnt + 9'd1;
          end
        endcase
      end
    end
  end

  // APB slave: zero wait states, answer registered at the setup edge
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      pready  <= apb_setup;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      if (apb_setup)
      begin
        if (paddr == `ADDR_PEAK_POLICY)
          prdata <= {24'h00_0000, peak_policy[7], 1'b0, peak_policy[5:0]};
        else if (paddr == `ADDR_LEVEL_REBOUND)
          prdata <= {24'h00_0000, level_rebound};
        else if (paddr == `ADDR_PRESTILL_WINDOW)
          prdata <= {24'h00_0000, prestill_window};
        else if (paddr == `ADDR_TIMING_AXIS)
          prdata <= {16'h0000, timing_axis};
        else if (paddr == `ADDR_TAP_STATUS)
          prdata <= {24'h00_0000, taps, state, 1'b0, sticky};
        else
          pslverr <= 1'b1;
      end
    end
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      peak_policy     <= `RST_BYTE;
      // (RQ5) level enables reset to disabled
      level_rebound   <= `RST_BYTE;
      prestill_window <= `RST_BYTE;
      timing_axis     <= `RST_TIMING;
      sticky          <= 3'b000;
    end
    else
    begin
      if (apb_write && paddr == `ADDR_PEAK_POLICY)
        peak_policy <= {pwdata[7], 1'b0, pwdata[5:0]};
      if (apb_write && paddr == `ADDR_LEVEL_REBOUND)
        level_rebound <= pwdata[7:0];
      if (apb_write && paddr == `ADDR_PRESTILL_WINDOW)
        prestill_window <= pwdata[7:0];
      if (apb_write && paddr == `ADDR_TIMING_AXIS)
        timing_axis <= pwdata[15:0];
      // Write-one-to-clear; a flag raised in the same cycle survives
      for (k = 1; k < 4; k = k + 1)
        if (tap_event && tap_level == k)
          sticky[k-1] <= 1'b1;
        else if (apb_write && paddr == `ADDR_TAP_STATUS && pwdata[k-1])
          sticky[k-1] <= 1'b0;
    end
  end

endmodule // tap_event_detector

// ==== tb/tap_event_detector_chk.sv ====
// Port checker for the tap detector.
// Assumes one pclk domain, async active-low presetn.
`timescale 1ns/1ps
module tap_event_detector_chk (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pready,
  input wire        pslverr,
  input wire [31:0] prdata,
  input wire        sample_valid,
  input wire        tap_event,
  input wire [1:0]  tap_level
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup; psel && !penable; endsequence
  sequence s_flag; tap_event && tap_level != 2'h0; endsequence
  property p_ready_next; s_setup |=> pready; endproperty
  a_ready_next: assert property (p_ready_next) else $error("no ready after setup");
  property p_ready_pulse; pready |=> !pready; endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready held");
  property p_err_ready; pslverr |-> pready && prdata == 32'h0000_0000; endproperty
  a_err_ready: assert property (p_err_ready) else $error("error without ready");
  property p_rdata_idle; !pready |-> prdata == 32'h0000_0000; endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside access");
  property p_event_pulse; tap_event && !sample_valid |=> !tap_event; endproperty
  a_event_pulse: assert property (p_event_pulse) else $error("flag longer than a cycle");
  property p_event_cause; tap_event |-> $past(sample_valid); endproperty
  a_event_cause: assert property (p_event_cause) else $error("flag without sample");
  property p_level_valid; tap_event |-> s_flag; endproperty
  a_level_valid: assert property (p_level_valid) else $error("flag with level zero");
  property p_level_hold; !tap_event |-> $stable(tap_level); endproperty
  a_level_hold: assert property (p_level_hold) else $error("level moved without flag");
endmodule // tap_event_detector_chk

bind tap_event_detector tap_event_detector_chk u_tap_event_detector_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
  .pslverr(pslverr), .prdata(prdata), .sample_valid(sample_valid),
  .tap_event(tap_event), .tap_level(tap_level));

// ==== tb/tap_event_detector_test.sv ====
// Self-checking bench for the tap detector: registers and flag policy.
// Assumes a zero-wait APB slave and one-cycle sample strobes on pclk.
`timescale 1ns/1ps
`include "tap_event_map.vh"
module tap_event_detector_test;
  reg         pclk = 1'b0;
  reg         presetn = 1'b0;
  reg         psel = 1'b0;
  reg         penable = 1'b0;
  reg         pwrite = 1'b0;
  reg  [9:0]  paddr = 10'h000;
  reg  [31:0] pwdata = 32'h0000_0000;
  wire [31:0] prdata;
  wire        pready;
  wire        pslverr;
  reg         sample_valid = 1'b0;
  reg  [15:0] sample_x = 16'h0000;
  reg  [15:0] sample_y = 16'h0000;
  reg  [15:0] sample_z = 16'h0000;
  wire        tap_event;
  wire [1:0]  tap_level;
  integer     bad_count = 0;
  integer     samples_checked = 0;
  integer     ev_cnt = 0;
  reg  [31:0] rd;
  reg         er;
  always #50 pclk = ~pclk;
  always @(posedge pclk) if (tap_event === 1'b1) ev_cnt <= ev_cnt + 1;
  tap_event_detector u_tap_event_detector (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sample_valid(sample_valid), .sample_x(sample_x),
    .sample_y(sample_y), .sample_z(sample_z), .tap_event(tap_event), .tap_level(tap_level));
  task automatic chk(input [31:0] got, input [31:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp)
      begin
        bad_count = bad_count + 1;
        $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task automatic apb(input w, input [9:0] a, input [31:0] d);
    begin
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
        @(posedge pclk);
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task automatic rd_chk(input [9:0] a, input [31:0] exp, input e);
    begin
      apb(1'b0, a, 32'h0000_0000);
      chk(rd, exp);
      chk({31'h0, er}, {31'h0, e});
    end
  endtask
  task automatic smp(input [15:0] x, input [15:0] y);
    begin
      @(posedge pclk);
      sample_valid <= 1'b1;
      sample_x     <= x;
      sample_y     <= y;
      @(posedge pclk);
      sample_valid <= 1'b0;
    end
  endtask
  task automatic smp_z(input [15:0] z);
    begin
      @(posedge pclk);
      sample_valid <= 1'b1;
      sample_z     <= z;
      @(posedge pclk);
      sample_valid <= 1'b0;
    end
  endtask
  // Flag count and level, one edge after the last strobe lands
  task automatic settle(input [31:0] n, input [1:0] lvl);
    begin
      @(posedge pclk);
      #1;
      chk(ev_cnt, n);
      chk({30'h0, tap_level}, {30'h0, lvl});
    end
  endtask
  task automatic t_regs;
    begin
      rd_chk(`ADDR_PEAK_POLICY, 32'h0000_0000, 1'b0);
      rd_chk(`ADDR_LEVEL_REBOUND, 32'h0000_0000, 1'b0);
      rd_chk(`ADDR_PRESTILL_WINDOW, 32'h0000_0000, 1'b0);
      rd_chk(`ADDR_TIMING_AXIS, 32'h0000_0000, 1'b0);
      apb(1'b1, 10'h000, 32'h0000_00ff);
      rd_chk(10'h000, 32'h0000_0000, 1'b1);
      apb(1'b1, `ADDR_PEAK_POLICY, 32'h0000_00ff);
      rd_chk(`ADDR_PEAK_POLICY, 32'h0000_00bf, 1'b0);
      apb(1'b1, `ADDR_PRESTILL_WINDOW, 32'h0000_00de);
      rd_chk(`ADDR_PRESTILL_WINDOW, 32'h0000_00de, 1'b0);
      $display("registers done");
    end
  endtask
  task automatic t_now;
    begin
      apb(1'b1, `ADDR_PEAK_POLICY, 32'h0000_0001);
      apb(1'b1, `ADDR_LEVEL_REBOUND, 32'h0000_0060);
      apb(1'b1, `ADDR_PRESTILL_WINDOW, 32'h0000_0000);
      // Quiet threshold nonzero before relying on detection
      apb(1'b1, `ADDR_TIMING_AXIS, 32'h0000_1001);
      smp(16'h0000, 16'h0064);
      settle(0, 2'h0);
      smp(16'h000f, 16'h0000);
      settle(0, 2'h0);
      smp(16'h0010, 16'h0000);
      settle(1, 2'h1);
      smp(16'h0000, 16'h0000);
      smp(16'h0010, 16'h0000);
      settle(2, 2'h2);
      $display("immediate flags done");
    end
  endtask
  task automatic t_hold;
    begin
      apb(1'b1, `ADDR_PEAK_POLICY, 32'h0000_0081);
      apb(1'b1, `ADDR_LEVEL_REBOUND, 32'h0000_00e0);
      smp(16'h0010, 16'h0000);
      repeat (20) smp(16'h0000, 16'h0000);
      settle(3, 2'h1);
      smp(16'h0010, 16'h0000);
      smp(16'h0000, 16'h0000);
      smp(16'h0010, 16'h0000);
      settle(3, 2'h1);
      smp(16'h0000, 16'h0000);
      smp(16'h0010, 16'h0000);
      settle(4, 2'h3);
      apb(1'b1, `ADDR_LEVEL_REBOUND, 32'h0000_0000);
      smp(16'h0010, 16'h0000);
      repeat (20) smp(16'h0000, 16'h0000);
      settle(4, 2'h3);
      $display("held flags done");
    end
  endtask
  task automatic t_windows;
    begin
      apb(1'b1, `ADDR_PEAK_POLICY, 32'h0000_0081);
      apb(1'b1, `ADDR_LEVEL_REBOUND, 32'h0000_0060);
      apb(1'b1, `ADDR_TIMING_AXIS, 32'h0000_1102);
      smp(16'h0000, 16'h0010);
      repeat (15) smp(16'h0000, 16'h0000);
      // Idle clocks between samples must not age the window
      repeat (100) @(posedge pclk);
      repeat (16) smp(16'h0000, 16'h0000);
      settle(4, 2'h3);
      smp(16'h0000, 16'h0000);
      settle(5, 2'h1);
      apb(1'b1, `ADDR_PEAK_POLICY, 32'h0000_0001);
      apb(1'b1, `ADDR_LEVEL_REBOUND, 32'h0000_0061);
      apb(1'b1, `ADDR_TIMING_AXIS, 32'h0000_1007);
      smp_z(16'h0010);
      settle(6, 2'h1);
      repeat (2) smp_z(16'h0010);
      settle(6, 2'h1);
      repeat (2) smp_z(16'h0010);
      settle(6, 2'h1);
      smp_z(16'h0010);
      settle(7, 2'h2);
      repeat (4) smp_z(16'h0000);
      apb(1'b1, `ADDR_LEVEL_REBOUND, 32'h0000_0060);
      apb(1'b1, `ADDR_TIMING_AXIS, 32'h0000_1003);
      apb(1'b1, `ADDR_PRESTILL_WINDOW, 32'h0000_00c2);
      smp_z(16'hfff1);
      smp_z(16'h000f);
      smp_z(16'h0010);
      settle(7, 2'h2);
      smp_z(16'h0010);
      settle(8, 2'h1);
      apb(1'b0, `ADDR_TAP_STATUS, 32'h0000_0000);
      chk(rd & 32'h0000_0007, 32'h0000_0007);
      apb(1'b1, `ADDR_TAP_STATUS, 32'h0000_0001);
      apb(1'b0, `ADDR_TAP_STATUS, 32'h0000_0000);
      chk(rd & 32'h0000_0007, 32'h0000_0006);
      $display("windows and status done");
    end
  endtask
  task automatic complete_run;
    begin
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  initial
  begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_now;
    t_hold;
    t_windows;
    complete_run;
  end
  // Run needs a few hundred cycles; allow ten times that
  initial
  begin
    #400000;
    bad_count = bad_count + 1;
    complete_run;
  end
endmodule // tap_event_detector_test
